// *** stdac_host.sv ***
// stdac_host: serial host model that drives the converter control port
`timescale 1ns/1ps
`default_nettype none
module stdac_host (
  input  wire logic clk,
  input  wire logic dout_o,
  input  wire logic dout_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  // serial clock stands low between frames; chip select high unless keep_cs holds it low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // half a serial period: 4 master clocks, 100 ns
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // one frame msb first; fewer bits leave a partial frame behind
  // shared frame format
  task automatic xfer(input logic [15:0] frm, input int nbits, input bit keep_cs,
                      output logic [7:0] rd, output logic oe_n_seen);
    int i;
    rd = 8'h00;
    oe_n_seen = 1'b1;
    @(negedge clk);
    cs_n = 1'b0;
    half();
    for (i = 0; i < nbits; i++) begin
      din = frm[15-i];
      half();
      if (i >= 8) rd = {rd[6:0], dout_o};
      if (i == 8) oe_n_seen = dout_oe_n;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    // released line shows the inverse so a stale bit never passes
    din = ~din;
    if (!keep_cs) cs_n = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// *** stdac_mod.sv ***
// stdac_mod: first-order ones-density modulator
`timescale 1ns/1ps
`default_nettype none
module stdac_mod #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         step_en,
  input  wire logic [W-1:0] level,
  output logic              bit_out
);
  logic [W-1:0] acc_ff;
  logic         bit_ff;

  // two's complement to offset binary: zero gives half ones density
  wire logic [W-1:0] ubin = level ^ {1'b1, {(W-1){1'b0}}};
  wire logic [W:0]   sum  = {1'b0, acc_ff} + {1'b0, ubin};

  // carry out of the accumulator is the output bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= '0;
      bit_ff <= 1'b0;
    end else if (step_en) begin
      acc_ff <= sum[W-1:0];
      bit_ff <= sum[W];
    end
  end

  assign bit_out = bit_ff;
endmodule
`default_nettype wire

// *** stdac_pkg.sv ***
// stdac_pkg: shared constants and types of the test-signal converter control
package stdac_pkg;

  // serial idle timeout, in master clock cycles (2^18)
  localparam int unsigned SCLK_IDLE_CYC = 262144;
  // external bitstream and modulator rate divider
  localparam int unsigned BITSTREAM_DIV = 16;

  // serial frame layout: rw flag, register address, data byte
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned HDR_BITS     = 8;
  localparam int unsigned HDR_RW_BIT   = 7;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned NUM_REGS     = 10;

  // register addresses
  localparam logic [3:0] ADR_CFG    = 4'h0;
  localparam logic [3:0] ADR_SINEG  = 4'h1;
  localparam logic [3:0] ADR_MDIV   = 4'h2;
  localparam logic [3:0] ADR_NDIV   = 4'h3;
  localparam logic [3:0] ADR_DC_HI  = 4'h4;
  localparam logic [3:0] ADR_DC_MID = 4'h5;
  localparam logic [3:0] ADR_DC_LO  = 4'h6;
  localparam logic [3:0] ADR_PULSA  = 4'h7;
  localparam logic [3:0] ADR_PULSB  = 4'h8;
  localparam logic [3:0] ADR_SWCTL  = 4'h9;

  // field positions
  localparam int unsigned CFG_MODE_LSB   = 0;
  localparam int unsigned CFG_GAIN_LSB   = 2;
  localparam int unsigned MDIV_FREQ_BIT  = 4;
  localparam int unsigned SWCTL_PIN_BIT  = 0;
  localparam int unsigned SWCTL_CMD_BIT  = 1;

  // reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [7:0] RST_SWCTL = 8'h01;

  // highest of the seven analog ranges
  localparam logic [2:0] GAIN_MAX  = 3'h6;

  // sine phase width: 2^14 steps per period
  localparam int unsigned PHASE_W = 14;

  typedef enum logic [1:0] {
    MODE_SINE  = 2'h0,
    MODE_DC    = 2'h1,
    MODE_DATA  = 2'h2,
    MODE_PULSE = 2'h3
  } stdac_mode_t;

endpackage

// *** stdac_sine.sv ***
// stdac_sine: sine generator with fractional rate divider and digital gain
`timescale 1ns/1ps
`default_nettype none
module stdac_sine (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        restart,
  input  wire logic        freq_div2,
  input  wire logic [3:0]  m_div,
  input  wire logic [7:0]  n_div,
  input  wire logic [7:0]  atten,
  output logic      [23:0] sample
);
  // quarter-wave table, 16 points at mid-bin angles
  localparam logic [15:0] QSIN [16] = '{
    16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f, 16'h36ba, 16'h41ce, 16'h4c3f, 16'h55f5,
    16'h5ed7, 16'h66cf, 16'h6dc9, 16'h73b5, 16'h7883, 16'h7c29, 16'h7e9d, 16'h7fd8};
  // half-decibel mantissas over one 6 dB octave
  localparam logic [15:0] MANT [12] = '{
    16'hffff, 16'hf1b1, 16'he42c, 16'hd766, 16'hcb58, 16'hbff9,
    16'hb539, 16'hab16, 16'ha189, 16'h9880, 16'h8ff3, 16'h87e9};

  logic                              pre_ff;
  logic [8:0]                        acc_ff;
  logic [stdac_pkg::PHASE_W-1:0]     phase_ff;
  logic [23:0]                       sample_ff;

  // fractional step: phase advances (m+1)/(n+1) per enabled clock while m <= n, else one step per enabled clock
  wire logic        step_en  = ~freq_div2 | pre_ff;
  wire logic [8:0]  m_plus   = {5'h00, m_div} + 9'h001;
  wire logic [8:0]  n_plus   = {1'b0, n_div} + 9'h001;
  wire logic [8:0]  acc_sum  = acc_ff + m_plus;
  wire logic        wrap     = acc_sum >= n_plus;
  wire logic [1:0]  quad     = phase_ff[13:12];
  wire logic [3:0]  idx      = quad[0] ? ~phase_ff[11:8] : phase_ff[11:8];
  wire logic [15:0] mag      = QSIN[idx];
  wire logic signed [16:0] sval = quad[1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  wire logic [4:0]  shift    = 5'(atten / 8'd12);
  wire logic [3:0]  midx     = 4'(atten % 8'd12);
  wire logic signed [33:0] prod = sval * $signed({1'b0, MANT[midx]});
  // part-select drops the sign, so restore it before the arithmetic shift
  wire logic signed [23:0] scaled = $signed(prod[31:8]) >>> shift;
  wire logic        mute     = atten[7:4] == 4'hf;

  // phase accumulator; restart lands on the rising zero crossing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff   <= 1'b0;
      acc_ff   <= 9'h000;
      phase_ff <= '0;
    end else if (restart) begin
      pre_ff   <= 1'b0;
      acc_ff   <= 9'h000;
      phase_ff <= '0;
    end else begin
      pre_ff <= ~pre_ff;
      if (step_en) begin
        acc_ff <= wrap ? acc_sum - n_plus : acc_sum;
        if (wrap) begin
          phase_ff <= phase_ff + 1'b1;
        end
      end
    end
  end

  // gain stage registered so the sample is a clean flop output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_ff <= 24'h000000;
    end else begin
      sample_ff <= mute ? 24'h000000 : scaled;
    end
  end

  assign sample = sample_ff;
endmodule
`default_nettype wire

// *** stdac_top.sv ***
// stdac_top: serial-configured control of the seismic test-signal converter
//
// Function
// - serial logic resets after long sclk low
// - works with chip select tied low
// - sample on sclk rise, shift on fall
// - dout driven only while chip select low
// - every register readable on dout
// - power-on reset sets defaults
// - modulator turns sine or dc into bitstream
// - data mode bitstream bypasses generator and modulator
// - sine frequency programmable by register
// - analog 6 dB and digital 0.5 dB gain
// - analog gain picks one of seven ranges
// - dc mode outputs 24-bit register level
// - pulse mode drives 5-bit fast converter
// - sync level picks pulse level a or b
// - sync restarts sine at zero crossing
// - reset pin low powers down, release resets
// - powered down outputs are high impedance
// - data mode: dual pin is bitstream input
// - other modes: dual pin drives switch
// - switch by pin or serial command
// - two-bit mode field selects output mode
`timescale 1ns/1ps
`default_nettype none
module stdac_top #(
  parameter int unsigned SCLK_IDLE_CYC = stdac_pkg::SCLK_IDLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout_o,
  output logic             dout_oe_n,
  input  wire logic        sync_in,
  input  wire logic        switch_or_bitstream_in,
  output logic             main_bit,
  output logic      [2:0]  analog_range_amp,
  output logic      [4:0]  pulse_code,
  output logic             pulse_sel,
  output logic             switch_closed,
  output logic             out_pos_oe_n,
  output logic             out_neg_oe_n
);
  localparam int unsigned IDX_SCLK = 0;
  localparam int unsigned IDX_CS   = 1;
  localparam int unsigned IDX_DIN  = 2;
  localparam int unsigned IDX_RPD  = 3;
  localparam int unsigned IDX_SYNC = 4;
  localparam int unsigned IDX_SW   = 5;
  localparam int unsigned IDLE_W   = $clog2(SCLK_IDLE_CYC + 1);

  logic [5:0]        meta_ff;
  logic [5:0]        pin_s_ff;
  logic [5:0]        pin_d_ff;
  logic [IDLE_W-1:0] idle_cnt_ff;
  logic [4:0]        bit_cnt_ff;
  logic [14:0]       shin_ff;
  logic [7:0]        rd_sr_ff;
  logic              dout_ff;
  logic [7:0]        regs_ff [stdac_pkg::NUM_REGS];
  logic [3:0]        div_cnt_ff;
  logic              pd_ff;
  logic              main_bit_ff;
  logic [2:0]        amp_ff;
  logic [4:0]        pulse_ff;
  logic              sw_ff;

  // synchronised pin levels and edges
  wire logic sclk_s   = pin_s_ff[IDX_SCLK];
  wire logic cs_s     = pin_s_ff[IDX_CS];
  wire logic din_s    = pin_s_ff[IDX_DIN];
  wire logic sync_s   = pin_s_ff[IDX_SYNC];
  wire logic dual_s   = pin_s_ff[IDX_SW];
  wire logic sclk_rise = sclk_s & ~pin_d_ff[IDX_SCLK];
  wire logic sclk_fall = ~sclk_s & pin_d_ff[IDX_SCLK];
  wire logic sync_rise = sync_s & ~pin_d_ff[IDX_SYNC];
  // reset pin low means power down
  wire logic pd       = ~pin_s_ff[IDX_RPD];

  // idle timeout after the sclk-low limit
  wire logic spi_to    = idle_cnt_ff == IDLE_W'(SCLK_IDLE_CYC);
  wire logic frame_rst = cs_s | spi_to | pd;

  // frame decode: header byte, then data byte
  wire logic [15:0] frame   = {shin_ff, din_s};
  wire logic        last_bit = bit_cnt_ff == 5'(stdac_pkg::FRAME_BITS - 1);
  wire logic        hdr_done = bit_cnt_ff == 5'(stdac_pkg::HDR_BITS);
  wire logic        in_data  = bit_cnt_ff > 5'(stdac_pkg::HDR_BITS);
  wire logic        wr_en    = sclk_rise & last_bit & ~frame[8 + stdac_pkg::HDR_RW_BIT];
  wire logic [3:0]  wr_addr  = frame[11:8];
  wire logic [7:0]  wr_data  = frame[7:0];
  wire logic [3:0]  rd_addr  = shin_ff[3:0];
  wire logic        rd_ok    = rd_addr < 4'(stdac_pkg::NUM_REGS);
  wire logic [7:0]  rdata    = rd_ok ? regs_ff[rd_addr] : 8'h00;
  wire logic        mn_wr    = wr_en & ((wr_addr == stdac_pkg::ADR_MDIV) |
                                         (wr_addr == stdac_pkg::ADR_NDIV));

  wire stdac_pkg::stdac_mode_t mode =
    stdac_pkg::stdac_mode_t'(regs_ff[stdac_pkg::ADR_CFG][stdac_pkg::CFG_MODE_LSB +: 2]);
  wire logic [2:0]  gain_raw = regs_ff[stdac_pkg::ADR_CFG][stdac_pkg::CFG_GAIN_LSB +: 3];
  wire logic [23:0] dc_level = {regs_ff[stdac_pkg::ADR_DC_HI],
                                regs_ff[stdac_pkg::ADR_DC_MID],
                                regs_ff[stdac_pkg::ADR_DC_LO]};
  wire logic [7:0]  swctl    = regs_ff[stdac_pkg::ADR_SWCTL];
  wire logic        is_data  = mode == stdac_pkg::MODE_DATA;
  wire logic        is_pulse = mode == stdac_pkg::MODE_PULSE;
  wire logic        is_sine  = mode == stdac_pkg::MODE_SINE;
  wire logic        mod_step = div_cnt_ff == 4'(stdac_pkg::BITSTREAM_DIV - 1);
  wire logic [23:0] sine_smp;
  wire logic        mod_bit;
  // sync or a divider write restarts the sine
  wire logic        sine_restart = pd | mn_wr | (is_sine & sync_rise);
  // modulator source: dc register or sine
  wire logic [23:0] mod_src  = (mode == stdac_pkg::MODE_DC) ? dc_level : sine_smp;
  // pin or command closes the switch
  wire logic        sw_by_pin = swctl[stdac_pkg::SWCTL_PIN_BIT] & ~is_data;
  wire logic        sw_next   = sw_by_pin ? dual_s : swctl[stdac_pkg::SWCTL_CMD_BIT];

  // two-stage synchronisers; constants only under reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff  <= 6'h02;
      pin_s_ff <= 6'h02;
      pin_d_ff <= 6'h02;
    end else begin
      meta_ff  <= {switch_or_bitstream_in, sync_in, reset_powerdown_n, din, cs_n, sclk};
      pin_s_ff <= meta_ff;
      pin_d_ff <= pin_s_ff;
    end
  end

  // count master clocks while sclk stays low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_ff <= '0;
    end else if (sclk_s | spi_to) begin
      idle_cnt_ff <= '0;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end

  // shift in on rise; timeout regains framing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= 5'h00;
      shin_ff    <= 15'h0000;
    end else if (frame_rst) begin
      bit_cnt_ff <= 5'h00;
    end else if (sclk_rise) begin
      shin_ff    <= frame[14:0];
      bit_cnt_ff <= last_bit ? 5'h00 : bit_cnt_ff + 1'b1;
    end
  end

  // load read data after the header, shift on each fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sr_ff <= 8'h00;
      dout_ff  <= 1'b0;
    end else if (frame_rst) begin
      dout_ff  <= 1'b0;
    end else if (sclk_fall & hdr_done) begin
      dout_ff  <= rdata[7];
      rd_sr_ff <= {rdata[6:0], 1'b0};
    end else if (sclk_fall & in_data) begin
      dout_ff  <= rd_sr_ff[7];
      rd_sr_ff <= {rd_sr_ff[6:0], 1'b0};
    end
  end

  // last rising edge of a write frame stores the byte
  // power-down holds every register at its default
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < stdac_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= stdac_pkg::RST_REG;
      end
      regs_ff[stdac_pkg::ADR_SWCTL] <= stdac_pkg::RST_SWCTL;
    end else if (pd) begin
      for (int i = 0; i < stdac_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= stdac_pkg::RST_REG;
      end
      regs_ff[stdac_pkg::ADR_SWCTL] <= stdac_pkg::RST_SWCTL;
    end else if (wr_en && wr_addr < 4'(stdac_pkg::NUM_REGS)) begin
      regs_ff[wr_addr] <= wr_data;
    end
  end

  // divider matches the external bitstream rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 4'h0;
    end else begin
      div_cnt_ff <= mod_step ? 4'h0 : div_cnt_ff + 1'b1;
    end
  end

  stdac_sine u_sine (
    .clk       (clk),
    .arst_n    (arst_n),
    .restart   (sine_restart),
    .freq_div2 (regs_ff[stdac_pkg::ADR_MDIV][stdac_pkg::MDIV_FREQ_BIT]),
    .m_div     (regs_ff[stdac_pkg::ADR_MDIV][3:0]),
    .n_div     (regs_ff[stdac_pkg::ADR_NDIV]),
    .atten     (regs_ff[stdac_pkg::ADR_SINEG]),
    .sample    (sine_smp)
  );

  // modulator fed from sine or dc level
  stdac_mod #(
    .W (24)
  ) u_mod (
    .clk     (clk),
    .arst_n  (arst_n),
    .step_en (mod_step),
    .level   (mod_src),
    .bit_out (mod_bit)
  );

  // output stage: converter bit, range, pulse level, switch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_ff       <= 1'b1;
      main_bit_ff <= 1'b0;
      amp_ff      <= 3'h0;
      pulse_ff    <= 5'h00;
      sw_ff       <= 1'b0;
    end else begin
      pd_ff       <= pd;
      // data mode feeds the pin straight through
      main_bit_ff <= ~pd & (is_data ? dual_s : mod_bit);
      // codes above the seventh range clamp to it
      amp_ff      <= (gain_raw > stdac_pkg::GAIN_MAX) ? stdac_pkg::GAIN_MAX : gain_raw;
      // sync level chooses the pulse register
      pulse_ff    <= (pd | ~is_pulse) ? 5'h00 :
                     (sync_s ? regs_ff[stdac_pkg::ADR_PULSB][4:0]
                             : regs_ff[stdac_pkg::ADR_PULSA][4:0]);
      // dual pin steers the switch outside data mode
      sw_ff       <= ~pd & sw_next;
    end
  end

  assign dout_oe_n        = cs_s | pd;
  assign dout_o           = dout_ff;
  assign main_bit         = main_bit_ff;
  assign analog_range_amp = amp_ff;
  assign pulse_code       = pulse_ff;
  assign pulse_sel        = pulse_ff != 5'h00 || is_pulse;
  assign switch_closed    = sw_ff;
  // both outputs released while powered down
  assign out_pos_oe_n     = pd_ff;
  assign out_neg_oe_n     = pd_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_write_frame;
    wr_en && wr_addr < 4'(stdac_pkg::NUM_REGS) && !pd;
  endsequence

  sequence s_header_done;
    sclk_fall && hdr_done && !frame_rst;
  endsequence

  chk_idle_timeout: assert property (spi_to |=> bit_cnt_ff == 5'h00)
    else $error("serial framing not reset after sclk idle");
  chk_cs_low_count: assert property (
    !frame_rst && sclk_rise && !last_bit |=> bit_cnt_ff == $past(bit_cnt_ff) + 5'h01)
    else $error("bit count did not advance on sclk rise");
  chk_dout_on_fall: assert property (
    $changed(dout_ff) |-> $past(sclk_fall) || $past(frame_rst))
    else $error("dout changed without a falling sclk");
  chk_dout_release: assert property (cs_s |-> dout_oe_n ##1 !dout_o)
    else $error("dout driven or not cleared while chip select high");
  chk_read_first_bit: assert property (s_header_done |=> dout_ff == $past(rdata[7]))
    else $error("read data msb not presented");
  chk_reg_write: assert property (
    s_write_frame |=> regs_ff[$past(wr_addr)] == $past(wr_data))
    else $error("register write lost");
  chk_data_bypass: assert property (
    is_data && !pd |=> main_bit == $past(dual_s))
    else $error("data mode bitstream not passed through");
  chk_pulse_select: assert property (
    is_pulse && !pd && sync_s |=> pulse_code == $past(regs_ff[stdac_pkg::ADR_PULSB][4:0]))
    else $error("pulse b not selected with sync high");
  chk_pd_outputs: assert property (
    pd ##1 pd |-> out_pos_oe_n && out_neg_oe_n && !main_bit && !switch_closed)
    else $error("outputs active during power down");
  chk_gain_clamp: assert property (##1 analog_range_amp <= stdac_pkg::GAIN_MAX)
    else $error("analog range beyond seventh step");
endmodule
`default_nettype wire

// *** test_seismic_test_signal_dac_control.sv ***
// test_seismic_test_signal_dac_control: self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
module test_seismic_test_signal_dac_control;
  // short idle timeout keeps the run brief
  localparam int unsigned IDLE = 64;
  logic       clk;
  logic       arst_n;
  logic       rpd_n;
  logic       sync_in;
  logic       sw_in;
  wire        sclk;
  wire        cs_n;
  wire        din;
  wire        dout_o;
  wire        dout_oe_n;
  wire        main_bit;
  wire  [2:0] amp;
  wire  [4:0] pulse_code;
  wire        pulse_sel;
  wire        sw_closed;
  wire        pos_oe_n;
  wire        neg_oe_n;
  int         error_cnt;
  int         n_checks;
  int         cyc;
  int         cnt_p;
  int         cnt_n;
  logic [7:0] rd;
  logic       oe;
  logic [7:0] pat [10];

  stdac_top #(.SCLK_IDLE_CYC(IDLE)) u_dut (
    .clk(clk), .arst_n(arst_n), .reset_powerdown_n(rpd_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .sync_in(sync_in),
    .switch_or_bitstream_in(sw_in), .main_bit(main_bit), .analog_range_amp(amp),
    .pulse_code(pulse_code), .pulse_sel(pulse_sel), .switch_closed(sw_closed),
    .out_pos_oe_n(pos_oe_n), .out_neg_oe_n(neg_oe_n)
  );

  stdac_host u_host (
    .clk(clk), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .sclk(sclk), .cs_n(cs_n), .din(din)
  );

  // 40 MHz master clock
  always #12.5 clk = ~clk;

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.xfer({4'h0, a, d}, 16, 1'b0, rd, oe);
  endtask

  task automatic rdb(input logic [3:0] a, input logic [7:0] exp);
    u_host.xfer({4'h8, a, 8'h00}, 16, 1'b0, rd, oe);
    check("rdata", rd, exp);
    check("dout enable mid frame", oe, 1'b0);
    check("dout enable idle", dout_oe_n, 1'b1);
  endtask

  // hang guard: the whole sequence needs well under 40000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    rpd_n = 1'b1;
    sync_in = 1'b0;
    sw_in = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    pat = '{8'h0d, 8'h5a, 8'h13, 8'hc4, 8'h12, 8'h34, 8'h56, 8'h0b, 8'h1c, 8'h03};
    wt(3);
    arst_n = 1'b1;
    wt(6);
    // defaults after power-on
    check("range", amp, 3'h0);
    check("pulse", pulse_code, 5'h00);
    check("out enables", {pos_oe_n, neg_oe_n}, 2'b00);
    for (int a = 0; a < 10; a++) begin
      rdb(a[3:0], a == 9 ? stdac_pkg::RST_SWCTL : stdac_pkg::RST_REG);
    end
    $display("test defaults done");
    // write every register, read back, then unmapped places
    for (int a = 0; a < 10; a++) wr(a[3:0], pat[a]);
    for (int a = 0; a < 10; a++) rdb(a[3:0], pat[a]);
    wr(4'ha, 8'h77);
    rdb(4'ha, 8'h00);
    rdb(4'hf, 8'h00);
    $display("test registers done");
    // every gain code, 7 clamps to the highest range
    for (int g = 0; g < 8; g++) begin
      wr(stdac_pkg::ADR_CFG, {3'h0, g[2:0], 2'h1});
      wt(6);
      check("range", amp, g > 6 ? stdac_pkg::GAIN_MAX : g[2:0]);
    end
    $display("test gain done");
    // every mode code; pulse levels picked by sync level
    for (int m = 0; m < 4; m++) begin
      wr(stdac_pkg::ADR_CFG, {6'h00, m[1:0]});
      wt(6);
      check("pulse select", pulse_sel, m == 3);
      check("pulse code", pulse_code, m == 3 ? 5'h0b : 5'h00);
    end
    sync_in = 1'b1;
    wt(8);
    check("pulse code b", pulse_code, 5'h1c);
    sync_in = 1'b0;
    wt(8);
    check("pulse code a", pulse_code, 5'h0b);
    $display("test modes done");
    // switch by pin or by command in sine mode
    wr(stdac_pkg::ADR_CFG, 8'h00);
    wr(stdac_pkg::ADR_SWCTL, 8'h01);
    sw_in = 1'b1;
    wt(8);
    check("switch pin high", sw_closed, 1'b1);
    sw_in = 1'b0;
    wt(8);
    check("switch pin low", sw_closed, 1'b0);
    wr(stdac_pkg::ADR_SWCTL, 8'h02);
    wt(6);
    check("switch command", sw_closed, 1'b1);
    wr(stdac_pkg::ADR_SWCTL, 8'h01);
    // data mode: pin is the bitstream at a sixteenth of the clock
    wr(stdac_pkg::ADR_CFG, 8'h02);
    // source holds each bit sixteen clocks
    for (int i = 0; i < 8; i++) begin
      sw_in = (i == 0) || (i == 4);
      wt(8);
      check("bitstream", main_bit, sw_in);
      check("switch ignores pin", sw_closed, 1'b0);
      wt(8);
    end
    sw_in = 1'b0;
    $display("test switch and data done");
    // dc full scale of each sign drives ones density apart
    wr(stdac_pkg::ADR_DC_HI, 8'h7f);
    wr(stdac_pkg::ADR_DC_MID, 8'hff);
    wr(stdac_pkg::ADR_DC_LO, 8'hff);
    wr(stdac_pkg::ADR_CFG, 8'h01);
    wt(64);
    cnt_p = 0;
    repeat (1024) begin
      wt(1);
      if (main_bit === 1'b1) cnt_p++;
    end
    wr(stdac_pkg::ADR_DC_HI, 8'h80);
    wr(stdac_pkg::ADR_DC_MID, 8'h00);
    wr(stdac_pkg::ADR_DC_LO, 8'h01);
    wt(64);
    cnt_n = 0;
    repeat (1024) begin
      wt(1);
      if (main_bit === 1'b1) cnt_n++;
    end
    check("positive density", cnt_p > 512, 1'b1);
    check("negative density", cnt_n < 512, 1'b1);
    $display("test dc done");
    // select held low: partial frame cleared by the idle timeout
    u_host.xfer(16'hffff, 5, 1'b1, rd, oe);
    wt(IDLE + 16);
    u_host.xfer({4'h0, stdac_pkg::ADR_SINEG, 8'ha5}, 16, 1'b1, rd, oe);
    u_host.xfer({4'h8, stdac_pkg::ADR_SINEG, 8'h00}, 16, 1'b0, rd, oe);
    check("after timeout", rd, 8'ha5);
    $display("test timeout done");
    // fastest sine, -6 dB digital gain, analog range 3; sync restarts phase
    wr(stdac_pkg::ADR_MDIV, 8'h00);
    wr(stdac_pkg::ADR_NDIV, 8'h00);
    wr(stdac_pkg::ADR_SINEG, 8'h0c);
    wr(stdac_pkg::ADR_CFG, 8'h0c);
    sync_in = 1'b1;
    // one period is 16384 clocks: look inside the rising and falling halves
    wt(1024);
    cnt_p = 0;
    repeat (2048) begin
      wt(1);
      if (main_bit === 1'b1) cnt_p++;
    end
    wt(6144);
    cnt_n = 0;
    repeat (2048) begin
      wt(1);
      if (main_bit === 1'b1) cnt_n++;
    end
    sync_in = 1'b0;
    check("sine positive half", cnt_p > 1200, 1'b1);
    check("sine negative half", cnt_n < 848, 1'b1);
    $display("test sine done");
    // power down floats the outputs and returns the registers to their defaults
    rpd_n = 1'b0;
    wt(6);
    check("down enables", {pos_oe_n, neg_oe_n}, 2'b11);
    check("down range", amp, 3'h0);
    rpd_n = 1'b1;
    wt(6);
    check("up enables", {pos_oe_n, neg_oe_n}, 2'b00);
    rdb(stdac_pkg::ADR_CFG, stdac_pkg::RST_REG);
    rdb(stdac_pkg::ADR_SINEG, stdac_pkg::RST_REG);
    $display("test power down done");
    print_verdict();
  end
endmodule
`default_nettype wire
